// File: verilog/uacd_consts.svh
`ifndef UACD_CONSTS_SVH
`define UACD_CONSTS_SVH

// ****************************************************************
// word opcodes, first two bits of every host word
// ****************************************************************
`define UACD_OP_WCFG   2'h3
`define UACD_OP_RCFG   2'h1
`define UACD_OP_WDATA  2'h2
`define UACD_OP_RDATA  2'h0

// ****************************************************************
// field positions inside a 16-bit word
// ****************************************************************
`define UACD_F_RXAV    15
`define UACD_F_TXMT    14
`define UACD_F_FEN_N   13
`define UACD_F_RM      10
`define UACD_F_PM      9
`define UACD_F_RAM     8
`define UACD_F_IR      7
`define UACD_F_PE      5
`define UACD_F_SHORT   4
`define UACD_F_BAUD    0
`define UACD_F_TE_N    10
`define UACD_F_RTS     9
`define UACD_F_EXTRA   8
`define UACD_F_FE      10
`define UACD_F_CTS     9

// ****************************************************************
// reset values
// ****************************************************************
`define UACD_BAUD_RST  4'h0
`define UACD_DATA_RST  8'h00
`define UACD_BIT_RST   1'h0

// ****************************************************************
// bit timing, in 16x sub-ticks
// ****************************************************************
`define UACD_SUB_LAST  4'hF
`define UACD_SUB_MID   4'h7
`define UACD_IR_PULSE  4'h3

`endif

// File: verilog/uacd_pkg.sv
`default_nettype none

package uacd_pkg;

  typedef enum logic [2:0] {
    UACD_TX_IDLE,
    UACD_TX_START,
    UACD_TX_DATA,
    UACD_TX_EXTRA,
    UACD_TX_STOP
  } uacd_tx_state_t;

  typedef enum logic [2:0] {
    UACD_RX_IDLE,
    UACD_RX_START,
    UACD_RX_DATA,
    UACD_RX_EXTRA,
    UACD_RX_STOP
  } uacd_rx_state_t;

endpackage

`default_nettype wire

// File: verilog/uacd_link_if.sv
`default_nettype none

interface uacd_link_if;
  logic [15:0] cfg_word;
  logic [15:0] data_word;
  logic [15:0] rx_word;
  logic        done;

  modport core (
    output cfg_word,
    output data_word,
    input  rx_word,
    input  done
  );

  modport link (
    input  cfg_word,
    input  data_word,
    output rx_word,
    output done
  );
endinterface

`default_nettype wire

// File: verilog/uacd_spi_link.sv
`default_nettype none

module uacd_spi_link (
  input  wire logic  sclk_i,
  input  wire logic  cs_n_i,
  input  wire logic  mosi_i,
  output logic       miso_o,
  uacd_link_if.link  lnk
);

  logic [3:0]  rise_cnt_r;
  logic [3:0]  fall_cnt_r;
  logic [14:0] shift_r;
  logic        cfg_sel_r;
  logic        done_r;
  logic [15:0] word_r;
  logic [15:0] resp;

  // ****************************************************************
  // receive side, clocked by the host's serial clock
  // ****************************************************************
  // sclk stops between frames, so the frame state is cleared by
  // chip select itself rather than by an edge that may never come
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      rise_cnt_r <= 4'h0;
      shift_r    <= 15'h0000;
      cfg_sel_r  <= 1'b0;
      done_r     <= 1'b0;
    end
    else
    begin
      rise_cnt_r <= rise_cnt_r + 4'h1;
      shift_r    <= {shift_r[13:0], mosi_i};
      if (rise_cnt_r == 4'h1)
      begin
        cfg_sel_r <= mosi_i;
      end
      if (rise_cnt_r == 4'hF)
      begin
        done_r <= 1'b1;
      end
    end
  end

  // the word only moves on the 16th bit, so a short frame leaves it
  always_ff @(posedge sclk_i)
  begin
    if (!cs_n_i && rise_cnt_r == 4'hF)
    begin
      word_r <= {shift_r, mosi_i};
    end
  end

  // ****************************************************************
  // transmit side, bit 15 first, next bits on falling edges
  // ****************************************************************
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      fall_cnt_r <= 4'h0;
    end
    else
    begin
      fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end

  // top two bits match in both words, so the late select is harmless
  assign resp        = cfg_sel_r ? lnk.cfg_word : lnk.data_word;
  assign miso_o      = resp[~fall_cnt_r];
  assign lnk.rx_word = word_r;
  assign lnk.done    = done_r;

endmodule

`default_nettype wire

// File: verilog/uacd_uart.sv
`default_nettype none
`include "uacd_consts.svh"


module uacd_uart #(
  parameter int FIFO_DEPTH    = 8,
  parameter int BAUD_PRESCALE = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  output logic      miso_oe_o,
  output logic      irq_o,
  output logic      irq_oe_o,
  input  wire logic cts_n_i,
  output logic      rts_n_o,
  input  wire logic rx_i,
  output logic      tx_o
);

  localparam int PW = $clog2(FIFO_DEPTH);

  uacd_link_if lnk ();

  uacd_spi_link u_link (
    .sclk_i (sclk_i),
    .cs_n_i (cs_n_i),
    .mosi_i (mosi_i),
    .miso_o (miso_o),
    .lnk    (lnk.link)
  );

  // ****************************************************************
  // crossings from pins and from the link clock
  // ****************************************************************
  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic done_meta_r, done_sync_r, done_prev_r;
  logic cts_meta_r, cts_sync_r;
  logic rx_meta_r, rx_sync_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_meta_r   <= 1'b1;
      cs_sync_r   <= 1'b1;
      cs_prev_r   <= 1'b1;
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
      done_prev_r <= 1'b0;
      cts_meta_r  <= 1'b1;
      cts_sync_r  <= 1'b1;
      rx_meta_r   <= 1'b1;
      rx_sync_r   <= 1'b1;
    end
    else
    begin
      cs_meta_r   <= cs_n_i;
      cs_sync_r   <= cs_meta_r;
      cs_prev_r   <= cs_sync_r;
      done_meta_r <= lnk.done;
      done_sync_r <= done_meta_r;
      done_prev_r <= done_sync_r;
      cts_meta_r  <= cts_n_i;
      cts_sync_r  <= cts_meta_r;
      rx_meta_r   <= rx_i;
      rx_sync_r   <= rx_meta_r;
    end
  end

  logic       cs_rise;
  logic       done_rise;
  logic       done_seen_r;
  logic       frame_ok;
  logic [1:0] op;

  assign cs_rise   = cs_sync_r & ~cs_prev_r;
  assign done_rise = done_sync_r & ~done_prev_r;
  assign op        = lnk.rx_word[15:14];
  assign frame_ok  = cs_rise & done_seen_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      done_seen_r <= 1'b0;
    end
    else if (done_rise)
    begin
      done_seen_r <= 1'b1;
    end
    else if (cs_rise)
    begin
      done_seen_r <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration and control bits
  // ****************************************************************
  logic [3:0] baud_divisor_select_r;
  logic       fifo_disable_n_r;
  logic       infrared_mode_select_r;
  logic       extra_bit_enable_r;
  logic       short_word_select_r;
  logic       extra_bit_irq_mask_r;
  logic       rx_available_mask_r;
  logic       activity_framing_mask_r;
  logic       rts_r;
  logic       wcfg;
  logic       wdata;

  assign wcfg  = frame_ok && op == `UACD_OP_WCFG;
  assign wdata = frame_ok && op == `UACD_OP_WDATA;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      baud_divisor_select_r   <= `UACD_BAUD_RST;
      fifo_disable_n_r        <= `UACD_BIT_RST;
      infrared_mode_select_r  <= `UACD_BIT_RST;
      extra_bit_enable_r      <= `UACD_BIT_RST;
      short_word_select_r     <= `UACD_BIT_RST;
      extra_bit_irq_mask_r    <= `UACD_BIT_RST;
      rx_available_mask_r     <= `UACD_BIT_RST;
      activity_framing_mask_r <= `UACD_BIT_RST;
    end
    else if (wcfg)
    begin
      baud_divisor_select_r   <= lnk.rx_word[`UACD_F_BAUD +: 4];
      fifo_disable_n_r        <= lnk.rx_word[`UACD_F_FEN_N];
      infrared_mode_select_r  <= lnk.rx_word[`UACD_F_IR];
      extra_bit_enable_r      <= lnk.rx_word[`UACD_F_PE];
      short_word_select_r     <= lnk.rx_word[`UACD_F_SHORT];
      extra_bit_irq_mask_r    <= lnk.rx_word[`UACD_F_PM];
      rx_available_mask_r     <= lnk.rx_word[`UACD_F_RM];
      activity_framing_mask_r <= lnk.rx_word[`UACD_F_RAM];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rts_r <= `UACD_BIT_RST;
    end
    else if (wdata)
    begin
      rts_r <= lnk.rx_word[`UACD_F_RTS];
    end
  end

  // ****************************************************************
  // baud sub-tick, sixteen per bit
  // ****************************************************************
  logic [15:0] div_cnt_r;
  logic [15:0] div_lim;
  logic        tick;

  assign div_lim = 16'(({12'h000, baud_divisor_select_r} + 16'h0001)
                   * 16'(BAUD_PRESCALE)) - 16'h0001;
  assign tick    = div_cnt_r >= div_lim;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || tick)
    begin
      div_cnt_r <= 16'h0000;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  uacd_pkg::uacd_tx_state_t tx_state_r;
  logic [8:0] tx_buf_r;
  logic       tx_full_r;
  logic [7:0] tx_shift_r;
  logic       tx_extra_r;
  logic [2:0] tx_idx_r;
  logic [3:0] tx_sub_r;
  logic       tx_take;
  logic       tx_level;
  logic [2:0] last_idx;

  assign last_idx = short_word_select_r ? 3'h6 : 3'h7;
  assign tx_take  = tick && tx_state_r == uacd_pkg::UACD_TX_IDLE && tx_full_r;

  // a word written while the buffer is still full is dropped
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_full_r <= 1'b0;
      tx_buf_r  <= 9'h000;
    end
    else if (wdata && !lnk.rx_word[`UACD_F_TE_N] && !tx_full_r)
    begin
      tx_full_r <= 1'b1;
      tx_buf_r  <= {lnk.rx_word[`UACD_F_EXTRA], lnk.rx_word[7:0]};
    end
    else if (tx_take)
    begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_state_r <= uacd_pkg::UACD_TX_IDLE;
      tx_shift_r <= 8'h00;
      tx_extra_r <= 1'b0;
      tx_idx_r   <= 3'h0;
      tx_sub_r   <= 4'h0;
    end
    else if (tick)
    begin
      tx_sub_r <= tx_sub_r + 4'h1;
      case (tx_state_r)
        uacd_pkg::UACD_TX_IDLE:
        begin
          tx_sub_r <= 4'h0;
          if (tx_full_r)
          begin
            tx_state_r <= uacd_pkg::UACD_TX_START;
            tx_shift_r <= tx_buf_r[7:0];
            tx_extra_r <= tx_buf_r[8];
            tx_idx_r   <= 3'h0;
          end
        end
        uacd_pkg::UACD_TX_START:
          if (tx_sub_r == `UACD_SUB_LAST)
          begin
            tx_state_r <= uacd_pkg::UACD_TX_DATA;
          end
        uacd_pkg::UACD_TX_DATA:
          if (tx_sub_r == `UACD_SUB_LAST)
          begin
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_idx_r   <= tx_idx_r + 3'h1;
            if (tx_idx_r == last_idx)
            begin
              tx_state_r <= extra_bit_enable_r ? uacd_pkg::UACD_TX_EXTRA
                                               : uacd_pkg::UACD_TX_STOP;
            end
          end
        uacd_pkg::UACD_TX_EXTRA:
          if (tx_sub_r == `UACD_SUB_LAST)
          begin
            tx_state_r <= uacd_pkg::UACD_TX_STOP;
          end
        uacd_pkg::UACD_TX_STOP:
          if (tx_sub_r == `UACD_SUB_LAST)
          begin
            tx_state_r <= uacd_pkg::UACD_TX_IDLE;
          end
        default:
          tx_state_r <= uacd_pkg::UACD_TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (tx_state_r)
      uacd_pkg::UACD_TX_START: tx_level = 1'b0;
      uacd_pkg::UACD_TX_DATA:  tx_level = tx_shift_r[0];
      uacd_pkg::UACD_TX_EXTRA: tx_level = tx_extra_r;
      default:                 tx_level = 1'b1;
    endcase
  end

  // infrared: a zero is a short low pulse at the start of the bit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_o <= 1'b1;
    end
    else if (infrared_mode_select_r)
    begin
      tx_o <= tx_level | (tx_sub_r >= `UACD_IR_PULSE);
    end
    else
    begin
      tx_o <= tx_level;
    end
  end

  // ****************************************************************
  // receiver
  // ****************************************************************
  uacd_pkg::uacd_rx_state_t rx_state_r;
  logic [7:0] rx_shift_r;
  logic       rx_extra_r;
  logic [2:0] rx_idx_r;
  logic [3:0] rx_sub_r;
  logic       rx_samp_r;
  logic       fe_r;
  logic       push;
  logic       bit_end;

  assign bit_end = tick && rx_sub_r == `UACD_SUB_LAST;
  assign push    = bit_end && rx_state_r == uacd_pkg::UACD_RX_STOP && rx_samp_r;

  // infrared: any low within the bit marks a zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_samp_r <= 1'b1;
    end
    else if (tick && infrared_mode_select_r)
    begin
      rx_samp_r <= (rx_sub_r == 4'h0 ? 1'b1 : rx_samp_r) & rx_sync_r;
    end
    else if (tick && rx_sub_r == `UACD_SUB_MID)
    begin
      rx_samp_r <= rx_sync_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_state_r <= uacd_pkg::UACD_RX_IDLE;
      rx_shift_r <= `UACD_DATA_RST;
      rx_extra_r <= 1'b0;
      rx_idx_r   <= 3'h0;
      rx_sub_r   <= 4'h0;
    end
    else if (tick)
    begin
      rx_sub_r <= rx_sub_r + 4'h1;
      case (rx_state_r)
        uacd_pkg::UACD_RX_IDLE:
        begin
          rx_sub_r <= 4'h1;
          if (!rx_sync_r)
          begin
            rx_state_r <= uacd_pkg::UACD_RX_START;
            rx_shift_r <= `UACD_DATA_RST;
            rx_extra_r <= 1'b0;
            rx_idx_r   <= 3'h0;
          end
        end
        uacd_pkg::UACD_RX_START:
          if (bit_end)
          begin
            rx_state_r <= rx_samp_r ? uacd_pkg::UACD_RX_IDLE
                                    : uacd_pkg::UACD_RX_DATA;
          end
        uacd_pkg::UACD_RX_DATA:
          if (bit_end)
          begin
            rx_shift_r[rx_idx_r] <= rx_samp_r;
            rx_idx_r             <= rx_idx_r + 3'h1;
            if (rx_idx_r == last_idx)
            begin
              rx_state_r <= extra_bit_enable_r ? uacd_pkg::UACD_RX_EXTRA
                                               : uacd_pkg::UACD_RX_STOP;
            end
          end
        uacd_pkg::UACD_RX_EXTRA:
          if (bit_end)
          begin
            rx_extra_r <= rx_samp_r;
            rx_state_r <= uacd_pkg::UACD_RX_STOP;
          end
        uacd_pkg::UACD_RX_STOP:
          if (bit_end)
          begin
            rx_state_r <= uacd_pkg::UACD_RX_IDLE;
          end
        default:
          rx_state_r <= uacd_pkg::UACD_RX_IDLE;
      endcase
    end
  end

  // hardware setting the flag wins over a config write clearing it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fe_r <= 1'b0;
    end
    else if (bit_end && rx_state_r == uacd_pkg::UACD_RX_STOP)
    begin
      fe_r <= !rx_samp_r;
    end
    else if (wcfg)
    begin
      fe_r <= 1'b0;
    end
  end

  // ****************************************************************
  // receive fifo, one entry deep when bypassed
  // ****************************************************************
  logic [8:0]  fifo_mem_r [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic [PW:0] cap;
  logic        do_push;
  logic        do_pop;
  logic        rx_avail;
  logic [7:0]  rx_data_field;
  logic        rx_extra_bit;

  assign cap      = fifo_disable_n_r ? (PW+1)'(1) : (PW+1)'(FIFO_DEPTH);
  assign do_push  = push && count_r < cap;
  assign rx_avail = count_r != '0;
  assign do_pop   = done_rise && !op[0] && rx_avail;

  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      fifo_mem_r[wr_ptr_r] <= {rx_extra_r & extra_bit_enable_r, rx_shift_r};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
      end
      if (do_pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
      end
      count_r <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  assign rx_data_field = rx_avail ? {fifo_mem_r[rd_ptr_r][7] & ~short_word_select_r,
                                     fifo_mem_r[rd_ptr_r][6:0]}
                                  : `UACD_DATA_RST;
  assign rx_extra_bit  = rx_avail & fifo_mem_r[rd_ptr_r][8];

  // ****************************************************************
  // readback words, frozen while a frame is in progress
  // ****************************************************************
  logic [15:0] cfg_word_r;
  logic [15:0] data_word_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg_word_r  <= 16'h4000;
      data_word_r <= 16'h4000;
    end
    else if (cs_sync_r)
    begin
      cfg_word_r  <= {rx_avail, ~tx_full_r, fifo_disable_n_r, 2'h0,
                      rx_available_mask_r, extra_bit_irq_mask_r,
                      activity_framing_mask_r, infrared_mode_select_r, 1'b0,
                      extra_bit_enable_r, short_word_select_r,
                      baud_divisor_select_r};
      data_word_r <= {rx_avail, ~tx_full_r, 3'h0, fe_r, ~cts_sync_r,
                      rx_extra_bit, rx_data_field};
    end
  end

  assign lnk.cfg_word  = cfg_word_r;
  assign lnk.data_word = data_word_r;
  assign miso_oe_o     = ~cs_n_i;

  // ****************************************************************
  // interrupt and handshake pins
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_oe_o <= 1'b0;
      rts_n_o  <= 1'b1;
    end
    else
    begin
      irq_oe_o <= (extra_bit_irq_mask_r & rx_extra_bit)
                | (rx_available_mask_r & rx_avail)
                | (activity_framing_mask_r & fe_r);
      rts_n_o  <= ~rts_r;
    end
  end

  assign irq_o = 1'b0;

endmodule

`default_nettype wire

// File: tb/uacd_uart_sva.sv
`default_nettype none
module uacd_uart_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic irq_o,
  input wire logic irq_oe_o,
  input wire logic cts_n_i,
  input wire logic rts_n_o,
  input wire logic rx_i,
  input wire logic tx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [11:0] low_cnt_r;
  // longest legal low run: start plus nine zero bits at the slowest divisor
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || tx_o)
      low_cnt_r <= 12'h000;
    else if (low_cnt_r != 12'hFFF)
      low_cnt_r <= low_cnt_r + 12'h001;
  end
  oe_on_a:
    assert property (!cs_n_i |-> miso_oe_o) else $error("miso off in frame");
  oe_off_a:
    assert property (cs_n_i |-> !miso_oe_o) else $error("miso on outside frame");
  irq_data_a:
    assert property (irq_o == 1'b0) else $error("irq data not low");
  reset_idle_a:
    assert property ($rose(rst_n_i) |-> rts_n_o && tx_o && !irq_oe_o) else $error("reset level");
  rts_apply_a:
    assert property ($changed(rts_n_o) |-> $past(cs_n_i)) else $error("rts moved in frame");
  rts_hold_a:
    assert property ($fell(cs_n_i) |=> $stable(rts_n_o)[*4]) else $error("rts moved early");
  tx_min_low_a:
    assert property ($fell(tx_o) |-> !tx_o[*3]) else $error("tx low too short");
  tx_max_low_a:
    assert property (low_cnt_r <= 12'hA00) else $error("tx stuck low");
endmodule
`default_nettype wire

// File: tb/uacd_host.sv
`default_nettype none
module uacd_host (
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        mosi_o,
  input  wire logic   miso_i,
  output logic [15:0] rd_o,
  output logic        tgl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    rd_o = 16'h0000;
    tgl_o = 1'b0;
  end
  // n below 16 aborts the word; clock stands low outside frames
  task automatic xfer(input logic [15:0] w, input int n, input bit note);
    cs_n_o = 1'b0;
    #110;
    for (int k = 15; k > 15 - n; k--)
    begin
      mosi_o = w[k];
      #15 sclk_o = 1'b1;
      rd_o[k] = miso_i;
      #15 sclk_o = 1'b0;
    end
    mosi_o = ~mosi_o;
    #110 cs_n_o = 1'b1;
    #160;
    if (note)
      tgl_o = ~tgl_o;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i;
  logic        rst_n;
  logic        cts_n;
  logic        rx;
  logic        brk;
  logic        cfg_l;
  logic        cfg_pe;
  logic [3:0]  cfg_baud;
  logic [15:0] seed;
  logic [15:0] exp_rd_q[$];
  logic [8:0]  exp_tx_q[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  wire         sclk, cs_n, mosi, miso, miso_oe, irq, irq_oe, rts_n, tx, tgl;
  wire  [15:0] rd_w;
  wire         miso_w = miso_oe ? miso : 1'bz;

  uacd_uart dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .irq_o(irq), .irq_oe_o(irq_oe),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .rx_i(rx), .tx_o(tx)
  );
  uacd_host host_u (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w), .rd_o(rd_w), .tgl_o(tgl)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // loopback; brk pulls the line low to force a bad stop bit
  always @(posedge clk_i) rx <= tx & ~brk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks_done++;
    n_mismatch += int'(!ok);
    if (!ok)
      $display("CHECK FAILED t=%0t %s", $time, m);
  endtask
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    chk(g === e, "reply word");
  endtask
  task automatic cmp_char(input logic [8:0] e, input logic [8:0] g);
    chk(g === e, "serial char");
  endtask
  task automatic cmp_pin(input logic e, input logic g);
    chk(g === e, "pin level");
  endtask
  task automatic spi(input logic [15:0] w, input int n, input logic [15:0] e, input bit note);
    if (note)
      exp_rd_q.push_back(e);
    host_u.xfer(w, n, note);
  endtask
  task automatic wait_for(input bit on_tx);
    int k;
    for (k = 0; k < 3000 && (k == 0 || (on_tx ? tx !== 1'b0 : irq_oe !== 1'b1)); k++)
      @(posedge clk_i);
    chk(k < 3000, "wait bound");
    if (k == 3000)
      end_of_test();
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always @(tgl)
    if (exp_rd_q.size() > 0)
      cmp_word(exp_rd_q.pop_front(), rd_w);

  always
  begin : tx_mon
    int         bt;
    logic [8:0] v;
    @(negedge tx);
    bt = (cfg_baud + 1) * 16;
    v = 9'h000;
    repeat (bt / 2) @(posedge clk_i);
    for (int k = 0; k < (cfg_l ? 7 : 8) + cfg_pe; k++)
    begin
      repeat (bt) @(posedge clk_i);
      v[k] = tx;
    end
    repeat (bt) @(posedge clk_i);
    cmp_pin(1'b1, tx);
    cmp_char(exp_tx_q.size() > 0 ? exp_tx_q.pop_front() : 9'h1FF, v);
  end

  // ****
  // scenarios
  // ****
  initial
  begin : main
    logic [15:0] c;
    logic [7:0]  d;
    logic        pt;
    logic [8:0]  e;
    rst_n = 1'b0;
    cts_n = 1'b0;
    brk = 1'b0;
    seed = 16'h0002;
    {cfg_l, cfg_pe, cfg_baud} = 6'h00;
    repeat (12) @(posedge clk_i);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    spi(16'h4000, 16, 16'h4000, 1);
    spi(16'h0000, 16, 16'h4200, 1);
    $display("test reset done");
    repeat (3)
    begin
      repeat (16) seed = lfsr(seed);
      c = 16'h4000 | seed & 16'h27BF;
      spi(16'hC000 | seed, 16, 0, 0);
      spi(16'h4000, 16, c, 1);
    end
    spi(16'hFFFF, 8, 0, 0);
    spi(16'h4000, 16, c, 1);
    $display("test config done");
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      d = seed[7:0];
      {cfg_pe, cfg_l} = 2'(i);
      cfg_baud = 4'(i);
      // extra bit written even when disabled, so the forced zero is seen
      pt = 1'b1;
      c = (cfg_pe ? 16'hC220 : 16'hC400) | 16'(cfg_l) << 4 | 16'(i);
      spi(c | (i == 3 ? 16'h2000 : 16'h0000), 16, 0, 0);
      e = cfg_l ? {2'b00, d[6:0]} : {1'b0, d};
      if (cfg_pe)
        e[cfg_l ? 7 : 8] = pt;
      exp_tx_q.push_back(e);
      spi(16'h8000 | 16'(!cfg_l) << 9 | 16'(pt) << 8 | 16'(d), 16, 0, 0);
      cmp_pin(cfg_l, rts_n);
      wait_for(1'b0);
      c = 16'hC200 | 16'(pt & cfg_pe) << 8 | 16'(cfg_l ? {1'b0, d[6:0]} : d);
      spi(16'h0000, 16, c, 1);
      spi(16'h0000, 16, 16'h4200, 1);
      cmp_pin(1'b0, irq_oe);
    end
    $display("test data done");
    {cfg_l, cfg_pe, cfg_baud} = 6'h00;
    spi(16'hC100, 16, 0, 0);
    @(posedge clk_i);
    cts_n <= 1'b1;
    exp_tx_q.push_back(9'h000);
    spi(16'h8000, 16, 0, 0);
    wait_for(1'b1);
    brk <= 1'b1;
    wait_for(1'b0);
    brk <= 1'b0;
    spi(16'h0000, 16, 16'h4400, 1);
    cmp_pin(1'b1, irq_oe);
    spi(16'hC100, 16, 0, 0);
    cmp_pin(1'b0, irq_oe);
    $display("test framing done");
    // infrared: zero bits are short pulses, so mid-bit samples read high
    spi(16'hC480, 16, 0, 0);
    exp_tx_q.push_back(9'h0FF);
    spi(16'h8000 | 16'(d), 16, 0, 0);
    wait_for(1'b0);
    spi(16'h0000, 16, 16'hC000 | 16'(d), 1);
    $display("test infrared done");
    end_of_test();
  end
endmodule

bind uacd_uart uacd_uart_sva sva_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i),
  .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
  .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .rx_i(rx_i), .tx_o(tx_o)
);
`default_nettype wire
